// ===== hw/flash_host.sv
// Function
// RL1 - host asserts select low only during its own transfers
// RL2 - every byte is written with a low pulse of the write strobe
// RL3 - command bytes go out with command latch high
// RL4 - address bytes go out with address latch high
// RL5 - read data taken only while read strobe is low
// RL6 - flash pulls ready/busy low during operations
// RL7 - ready/busy read as open-drain input with pull-up, synchronised
// RL8 - low byte always used, high byte only for wide memories
// RL9 - block is erase unit, page is write unit
// RL10 - small pages 528 bytes, 512 data plus 16 spare
// RL11 - large pages 2112 bytes, 2048 data plus 64 spare
// RL12 - host computes code over written data for spare area; wide bus codes low byte only
// RL13 - host recomputes code on read and corrects from stored one
// RL14 - one code per 256-byte chunk
// RL15 - single error corrected, double error flagged uncorrectable
// RL16 - host software checks status bytes and relocates bad blocks
// RL17 - programming clears bits only, erase sets all
// RL18 - host waits for ready before next command or data
// RL19 - never both latches, read strobe idle while writing
`timescale 1ns/1ps
module flash_host
  import flash_host_pkg::*;
#(
  parameter int WIDE = 0
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RESET,
  input  wire logic        CE,
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic [1:0]  REQ_KIND,
  input  wire logic [15:0] REQ_DATA,
  input  wire logic        REQ_WAIT_RDY,
  input  wire logic        REQ_LAST,
  output logic             RD_VALID,
  output logic [15:0]      RD_DATA,
  output logic             BUSY,
  output logic [ECC_BITS-1:0] ECC_CODE,
  output logic             ECC_DONE,
  input  wire logic [ECC_BITS-1:0] ECC_STORED,
  output logic             ECC_CORR,
  output logic             ECC_UNCORR,
  output logic [10:0]      ECC_FIX_POS,
  output logic             CHIP_SEL_N,
  output logic             WRITE_STROBE_N,
  output logic             READ_STROBE_N,
  output logic             CMD_LATCH,
  output logic             ADDR_LATCH,
  output logic [7:0]       BUS_LOW_BYTE_O,
  output logic [7:0]       BUS_HIGH_BYTE_O,
  output logic             BUS_OE,
  input  wire logic [7:0]  BUS_LOW_BYTE_I,
  input  wire logic [7:0]  BUS_HIGH_BYTE_I,
  input  wire logic        READY_BUSY_N
);
  state_t      state_reg, state_next;
  logic [3:0]  cnt_reg;
  logic [1:0]  kind_reg;
  logic [15:0] wdata_reg;
  logic        waitr_reg, last_reg;
  logic        rb_meta_reg, rb_sync_reg;
  logic [15:0] rin_meta_reg, rin_sync_reg;
  logic [15:0] rd_data_reg;
  logic        rd_valid_reg;
  logic        sel_reg;
  logic [7:0]  ecc_cnt_reg;
  logic [5:0]  col_reg;
  logic [15:0] line_reg;
  logic        ecc_done_reg;
  logic        done_reg;
  logic        chunk_rd_reg;
  logic [1:0]  settle_reg;
  logic        corr_reg, uncorr_reg;
  logic [10:0] fix_reg;

  wire         take      = CE && state_reg == ST_IDLE && REQ_VALID;
  wire         cnt_end   = cnt_reg == 4'(STROBE_CYC - 1);
  // busy reaches us late through the sync pair, so the pin is ignored briefly
  wire         settled   = settle_reg == 2'(RB_SETTLE_CYC);
  wire         is_rd     = kind_reg == KIND_RD;
  wire [1:0]   kind_now  = take ? REQ_KIND : kind_reg;
  wire [15:0]  wdata_now = take ? REQ_DATA : wdata_reg;
  wire         rb_ready  = rb_sync_reg; // RL7
  wire [7:0]   ecc_byte  = is_rd ? rin_sync_reg[7:0] : wdata_reg[7:0];
  wire         byte_done = CE && state_reg == ST_HOLD && cnt_end && kind_reg[1];
  wire         byte_par  = ^ecc_byte;
  wire [5:0]   col_upd;
  wire [ECC_BITS-1:0] syn = ECC_CODE ^ ECC_STORED;
  // each index parity paired with its complement: {byte index, bit index}
  wire [10:0]  syn_hi    = {syn[13:6], syn[5], syn[3], syn[1]};
  wire [10:0]  syn_lo    = {syn[21:14], syn[4], syn[2], syn[0]};

  // column parities: single bits, bit pairs, halves (odd/even)
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_col
      localparam int SP = 1 << g;
      logic [7:0] odd_m;
      for (genvar b = 0; b < 8; b++) begin : g_m
        assign odd_m[b] = ((b / SP) % 2) == 1;
      end
      assign col_upd[2*g]   = col_reg[2*g]   ^ (^(ecc_byte & ~odd_m));
      assign col_upd[2*g+1] = col_reg[2*g+1] ^ (^(ecc_byte & odd_m));
    end
  endgenerate

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (REQ_VALID) state_next = ST_SETUP;
      ST_SETUP: state_next = ST_PULSE;
      ST_PULSE: if (cnt_end) state_next = ST_HOLD;
      ST_HOLD:  if (cnt_end) state_next = waitr_reg ? ST_WAIT : ST_IDLE;
      ST_WAIT:  if (rb_ready && settled) state_next = ST_IDLE; // RL18
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 4'h0;
      settle_reg <= 2'h0;
      done_reg   <= 1'b0;
    end else if (CE) begin
      state_reg  <= state_next;
      cnt_reg    <= (state_next != state_reg || cnt_end) ? 4'h0 : cnt_reg + 4'h1;
      settle_reg <= state_reg != ST_WAIT ? 2'h0 : (settled ? settle_reg : settle_reg + 2'h1);
      done_reg   <= byte_done;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      kind_reg  <= KIND_CMD;
      wdata_reg <= 16'h0000;
      waitr_reg <= 1'b0;
      last_reg  <= 1'b0;
      sel_reg   <= 1'b0;
    end else if (CE) begin
      if (take) begin
        kind_reg  <= REQ_KIND;
        wdata_reg <= WIDE != 0 ? REQ_DATA : {8'h00, REQ_DATA[7:0]}; // RL8
        waitr_reg <= REQ_WAIT_RDY;
        last_reg  <= REQ_LAST;
        sel_reg   <= 1'b1; // RL1
      end else if (state_reg != ST_IDLE && state_next == ST_IDLE && last_reg) begin // RL1
        sel_reg   <= 1'b0;
      end
    end
  end

  // synchronisers for pins from the flash
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      // pull-up level, so no false busy follows reset
      rb_meta_reg  <= 1'b1;
      rb_sync_reg  <= 1'b1;
      rin_meta_reg <= 16'h0000;
      rin_sync_reg <= 16'h0000;
    end else if (CE) begin
      rb_meta_reg  <= READY_BUSY_N; // RL6
      rb_sync_reg  <= rb_meta_reg;
      rin_meta_reg <= {BUS_HIGH_BYTE_I, BUS_LOW_BYTE_I};
      rin_sync_reg <= rin_meta_reg;
    end
  end

  // taken once the strobe-low sample has passed both sync stages
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      rd_data_reg  <= 16'h0000;
      rd_valid_reg <= 1'b0;
    end else if (CE) begin
      rd_valid_reg <= done_reg && is_rd;
      if (done_reg && is_rd) begin // RL5
        rd_data_reg <= WIDE != 0 ? rin_sync_reg : {8'h00, rin_sync_reg[7:0]}; // RL8
      end
    end
  end

  // line-parity code per 256-byte chunk; wide bus codes low byte only
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ecc_cnt_reg  <= 8'h00;
      col_reg      <= 6'h00;
      line_reg     <= 16'h0000;
      ecc_done_reg <= 1'b0;
      chunk_rd_reg <= 1'b0;
    end else if (CE) begin
      ecc_done_reg <= done_reg && ecc_cnt_reg == 8'(CHUNK_BYTES - 1); // RL14
      if (done_reg) begin // RL12 RL13
        // both page data areas hold whole chunks, so the count wraps at the end of the data area
        ecc_cnt_reg <= ecc_cnt_reg + 8'h01; // RL10 RL11
        chunk_rd_reg <= is_rd;
        col_reg     <= ecc_cnt_reg == 8'h00 ? col_upd ^ col_reg : col_upd;
        line_reg    <= (ecc_cnt_reg == 8'h00 ? 16'h0000 : line_reg)
                       ^ ({16{byte_par}} & {~ecc_cnt_reg, ecc_cnt_reg});
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      corr_reg   <= 1'b0;
      uncorr_reg <= 1'b0;
      fix_reg    <= 11'h000;
    end else if (CE && ecc_done_reg && chunk_rd_reg) begin
      // RL15: one flipped bit toggles exactly one of each pair
      corr_reg   <= syn != '0 && (syn_hi ^ syn_lo) == 11'h7FF;
      uncorr_reg <= syn != '0 && (syn_hi ^ syn_lo) != 11'h7FF;
      fix_reg    <= syn_hi; // RL13
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      WRITE_STROBE_N <= 1'b1;
      READ_STROBE_N  <= 1'b1;
      CMD_LATCH      <= 1'b0;
      ADDR_LATCH     <= 1'b0;
      BUS_OE         <= 1'b0;
      BUS_LOW_BYTE_O <= 8'h00;
      BUS_HIGH_BYTE_O <= 8'h00;
    end else if (CE) begin
      CMD_LATCH  <= kind_now == KIND_CMD && state_next != ST_IDLE; // RL3 RL19
      ADDR_LATCH <= kind_now == KIND_ADDR && state_next != ST_IDLE; // RL4 RL19
      WRITE_STROBE_N <= !(state_next == ST_PULSE && !is_rd); // RL2
      READ_STROBE_N  <= !(state_next == ST_PULSE && is_rd); // RL5 RL19
      BUS_OE         <= state_next != ST_IDLE && state_next != ST_WAIT && kind_now != KIND_RD;
      BUS_LOW_BYTE_O <= wdata_now[7:0];
      BUS_HIGH_BYTE_O <= WIDE != 0 ? wdata_now[15:8] : 8'h00; // RL8
    end
  end

  assign CHIP_SEL_N  = !sel_reg; // RL1
  assign REQ_READY   = CE && state_reg == ST_IDLE;
  assign BUSY        = state_reg != ST_IDLE;
  assign RD_VALID    = rd_valid_reg;
  assign RD_DATA     = rd_data_reg;
  assign ECC_CODE    = {line_reg, col_reg};
  assign ECC_DONE    = ecc_done_reg;
  assign ECC_CORR    = corr_reg;
  assign ECC_UNCORR  = uncorr_reg;
  assign ECC_FIX_POS = fix_reg;

  never_both_latch_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // RL19
    !(CMD_LATCH && ADDR_LATCH)) else $error("both latches high");
  strobes_exclusive_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // RL19
    !(!WRITE_STROBE_N && !READ_STROBE_N)) else $error("both strobes low");
  strobe_needs_sel_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // RL1
    (!WRITE_STROBE_N || !READ_STROBE_N) |-> !CHIP_SEL_N) else $error("strobe without select");
  drive_not_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // RL5
    !READ_STROBE_N |-> !BUS_OE) else $error("driving bus during read");
  wait_ready_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // RL18
    (state_reg == ST_WAIT && !rb_sync_reg) |=> state_reg == ST_WAIT) else $error("left wait early");
  wr_rise_latch_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // RL2
    $rose(WRITE_STROBE_N) |-> BUS_OE) else $error("write edge without data");
  cmd_data_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // RL3
    (CMD_LATCH && !WRITE_STROBE_N) |-> kind_reg == KIND_CMD) else $error("cmd latch wrong");
  chunk_done_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // RL14
    ECC_DONE |-> ecc_cnt_reg == 8'h00) else $error("chunk count off");
  ecc_flags_a: assert property (@(posedge CLK_SYS) disable iff (RESET) // RL15
    !(ECC_CORR && ECC_UNCORR)) else $error("ecc flags both set");
endmodule

// ===== hw/flash_host_pkg.sv
package flash_host_pkg;
  localparam int CLK_HZ          = 25_000_000;
  localparam int STROBE_NS       = 40;
  localparam int STROBE_CYC      = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000 < 1 ? 1 :
                                   (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int RB_SETTLE_CYC   = 2;
  localparam int SMALL_DATA      = 512;
  localparam int SMALL_SPARE     = 16;
  localparam int SMALL_PAGE      = 528;
  localparam int LARGE_DATA      = 2048;
  localparam int LARGE_SPARE     = 64;
  localparam int LARGE_PAGE      = 2112;
  localparam int LARGE_PAGES_BLK = 64;
  localparam int CHUNK_BYTES     = 256;
  localparam int CHUNKS_LARGE    = 8;
  localparam int ECC_BITS        = 22;
  localparam int BUS_WIDE        = 16;
  localparam logic [1:0] KIND_CMD  = 2'h0;
  localparam logic [1:0] KIND_ADDR = 2'h1;
  localparam logic [1:0] KIND_WR   = 2'h2;
  localparam logic [1:0] KIND_RD   = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_PULSE = 3'b010,
    ST_HOLD  = 3'b011,
    ST_WAIT  = 3'b100
  } state_t;
endpackage

// ===== sim/flash_model.sv
`timescale 1ns/1ps
module flash_model #(
  parameter logic [7:0] BUSY_CMD = 8'h10,
  parameter int         BUSY_NS  = 2000,
  parameter int         HOLD_NS  = 80
) (
  input  wire logic       sel_n,
  input  wire logic       we_n,
  input  wire logic       read_strobe_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic [7:0] host_o,
  input  wire logic       host_oe,
  output logic [7:0]      bus_i,
  output logic            rb_n,
  output int              viol
);
  logic [7:0] mem [256];
  logic [7:0] ptr;
  logic [7:0] cmd;
  logic [7:0] dout;
  logic       drive;
  logic       busy;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {ptr, cmd, dout, drive, busy} = '0;
    viol = 0;
  end
  // released bus shows the inverse so a late sample cannot pass by luck
  assign bus_i = host_oe ? host_o : (drive ? dout : ~dout);
  assign rb_n  = busy ? 1'b0 : 1'b1;
  always @(posedge we_n) if (!sel_n) begin
    if ((cle && ale) || !read_strobe_n || busy) viol++;
    if (cle) begin
      cmd = bus_i;
      if (bus_i == BUSY_CMD) begin
        busy <= 1'b1;
        busy <= #BUSY_NS 1'b0;
      end
    end else if (ale) ptr = bus_i;
    else begin
      mem[ptr] = mem[ptr] & bus_i;
      ptr++;
    end
  end
  always @(negedge read_strobe_n) if (!sel_n) begin
    if (busy) viol++;
    dout = mem[ptr];
    ptr++;
    drive = 1'b1;
  end
  always @(posedge read_strobe_n) drive <= #HOLD_NS 1'b0;
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import flash_host_pkg::*;
  logic clk_sys = 0, reset = 1, ce = 1, req_valid = 0, req_wait = 0, req_last = 0;
  logic [1:0] req_kind = '0;
  logic [15:0] req_data = '0;
  logic [ECC_BITS-1:0] ecc_stored = '0, ecc_code, code_seen = '0, c1;
  logic req_ready, rd_valid, busy, ecc_done, ecc_corr, ecc_uncorr, chip_sel_n;
  logic we_n, read_strobe_n, cle, ale, bus_oe, rb_n;
  logic [15:0] rd_data;
  logic [10:0] fix_pos;
  logic [7:0] bus_lo_o, bus_hi_o, bus_lo_i, wdat [256], exp_mem [256];
  int failures = 0, total_checks = 0, done_cnt = 0, viol;
  always #20 clk_sys = ~clk_sys;
  flash_host uut (.CLK_SYS(clk_sys), .RESET(reset), .CE(ce), .REQ_VALID(req_valid),
    .REQ_READY(req_ready), .REQ_KIND(req_kind), .REQ_DATA(req_data),
    .REQ_WAIT_RDY(req_wait), .REQ_LAST(req_last), .RD_VALID(rd_valid), .RD_DATA(rd_data),
    .BUSY(busy), .ECC_CODE(ecc_code), .ECC_DONE(ecc_done), .ECC_STORED(ecc_stored),
    .ECC_CORR(ecc_corr), .ECC_UNCORR(ecc_uncorr), .ECC_FIX_POS(fix_pos),
    .CHIP_SEL_N(chip_sel_n), .WRITE_STROBE_N(we_n), .READ_STROBE_N(read_strobe_n),
    .CMD_LATCH(cle), .ADDR_LATCH(ale), .BUS_LOW_BYTE_O(bus_lo_o), .BUS_HIGH_BYTE_O(bus_hi_o),
    .BUS_OE(bus_oe), .BUS_LOW_BYTE_I(bus_lo_i), .BUS_HIGH_BYTE_I(8'h00),
    .READY_BUSY_N(rb_n));
  flash_model fm (.sel_n(chip_sel_n), .we_n(we_n), .read_strobe_n(read_strobe_n), .cle(cle),
    .ale(ale), .host_o(bus_lo_o), .host_oe(bus_oe), .bus_i(bus_lo_i), .rb_n(rb_n),
    .viol(viol));
  always @(posedge clk_sys) if (ecc_done === 1'b1) begin
    code_seen <= ecc_code;
    done_cnt++;
  end
  task test_done;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // valid stays up between writes so each signal changes once per step
  task xfer(input logic [1:0] k, input logic [7:0] d, input logic w, input logic l);
    req_kind = k;
    req_data = {8'h00, d};
    req_wait = w;
    req_last = l;
    req_valid = 1'b1;
    do @(posedge clk_sys); while (req_ready !== 1'b1);
    #1;
  endtask
  task reset_idle;
    `CHK({chip_sel_n, we_n, read_strobe_n, cle, ale, bus_oe}, 6'h38)
  endtask
  task refused;
    ce = 1'b0;
    req_valid = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(req_ready, 1'b0)
    `CHK(chip_sel_n, 1'b1)
    ce = 1'b1;
    req_valid = 1'b0;
  endtask
  task prog_chunk;
    xfer(KIND_CMD, 8'h80, 1'b0, 1'b0);
    xfer(KIND_ADDR, 8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 256; i++) begin
      xfer(KIND_WR, wdat[i], 1'b0, 1'b0);
      exp_mem[i] &= wdat[i];
    end
    xfer(KIND_CMD, 8'h10, 1'b1, 1'b1);
    req_valid = 1'b0;
    // the program ends only when the block has seen ready again
    do @(posedge clk_sys); while (busy !== 1'b0);
    #1;
    `CHK(rb_n, 1'b1)
    `CHK(fm.cmd, 8'h10)
    `CHK(chip_sel_n, 1'b1)
    `CHK(bus_hi_o, 8'h00)
  endtask
  task read_chunk(input logic [21:0] st, input logic c, input logic u, input logic [10:0] p);
    ecc_stored = st;
    xfer(KIND_CMD, 8'h00, 1'b0, 1'b0);
    xfer(KIND_ADDR, 8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 256; i++) begin
      xfer(KIND_RD, 8'h00, 1'b0, i == 255);
      req_valid = 1'b0;
      do @(posedge clk_sys); while (rd_valid !== 1'b1);
      #1;
      `CHK(rd_data[7:0], exp_mem[i])
    end
    repeat (6) @(posedge clk_sys);
    #1;
    `CHK({ecc_corr, ecc_uncorr}, {c, u})
    if (c) `CHK(fix_pos, p)
    if (!c && !u) `CHK(code_seen, st)
  endtask
  initial begin
    #(40 * 40000);
    failures++;
    test_done;
  end
  initial begin
    foreach (wdat[i]) wdat[i] = 8'(i) ^ 8'h5A;
    foreach (exp_mem[i]) exp_mem[i] = 8'hFF;
    repeat (16) @(posedge clk_sys);
    #1 reset = 1'b0;
    @(posedge clk_sys);
    #1;
    reset_idle;
    refused;
    prog_chunk;
    c1 = code_seen;
    read_chunk(c1, 1'b0, 1'b0, 11'h000);
    wdat[8'h2A][4] = 1'b0;
    prog_chunk;
    read_chunk(c1, 1'b1, 1'b0, {8'h2A, 3'h4});
    wdat[8'h51][0] = 1'b0;
    prog_chunk;
    read_chunk(c1, 1'b0, 1'b1, 11'h000);
    `CHK(viol, 0)
    `CHK(done_cnt, 6)
    test_done;
  end
endmodule
